// ---- hw/cpr_ch2_regs.v ----
`include "cpr_consts.vh"
`default_nettype none

module cpr_ch2_regs (
    // Clock and reset
    input wire clock_i,
    input wire arst_n_i,
    // Register port
    input wire [7:0] reg_addr_i,
    input wire [15:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    output reg [15:0] reg_rdata_o,
    // Channel status inputs
    input wire commanded_switch_state_i,
    input wire on_state_open_load_detect_enable_i,
    input wire open_load_trip_i,
    input wire overtemp_i,
    input wire [15:2] other_status_i,
    // Channel controls
    output reg gate_drive_o,
    output reg inrush_active_o,
    output reg wire_heating_protection_hold_o,
    output reg [1:0] capacitive_charge_mode_o,
    output reg [1:0] inrush_pulse_peak_threshold_o,
    output reg [3:0] inrush_level_setting_o,
    output reg pulse_error_o
);
    reg rst_s1_reg;
    reg rst_s2_reg;
    reg [15:0] pwm_ctrl_reg;
    reg [15:0] ilim_cfg_reg;
    reg sw_d_reg;
    reg [22:0] inrush_cnt_reg;
    wire pulse;
    wire short_on;

    // Reset release through two flops
    always @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_s1_reg <= 1'b0;
            rst_s2_reg <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_s2_reg <= rst_s1_reg;
        end
    end
    wire rst_n = rst_s2_reg;

    // Inrush period in clocks
    function [22:0] cpr_inrush_cyc;
        input [2:0] code;
        begin
            case (code)
                3'h0: cpr_inrush_cyc = 23'd0;
                3'h1: cpr_inrush_cyc = 23'd100000;
                3'h2: cpr_inrush_cyc = 23'd200000;
                3'h3: cpr_inrush_cyc = 23'd300000;
                3'h4: cpr_inrush_cyc = 23'd500000;
                3'h5: cpr_inrush_cyc = 23'd1000000;
                3'h6: cpr_inrush_cyc = 23'd2500000;
                default: cpr_inrush_cyc = 23'd5000000;
            endcase
        end
    endfunction

    wire [1:0] chg_mode = ilim_cfg_reg[`CPR_CHG_MSB:`CPR_CHG_LSB];
    wire pwm_en = pwm_ctrl_reg[`CPR_PWM_EN_BIT];
    wire mode_ok = (chg_mode == `CPR_CHG_NONE);
    wire inrush_now = (inrush_cnt_reg != 23'h0);
    wire pulse_run = pwm_en & mode_ok & commanded_switch_state_i & ~inrush_now & ~short_on;
    wire pwm_err = pwm_en & commanded_switch_state_i & (short_on | ~mode_ok);

    cpr_pulse_gen u_pulse (
        .clock_i(clock_i),
        .rst_n_i(rst_n),
        .run_i(pulse_run),
        .freq_code_i(pwm_ctrl_reg[`CPR_FREQ_MSB:`CPR_FREQ_LSB]),
        .duty_i(pwm_ctrl_reg[`CPR_DUTY_MSB:`CPR_DUTY_LSB]),
        .pulse_o(pulse),
        .short_on_o(short_on)
    );

    // Live fault status view
    wire [15:0] status;
    assign status[`CPR_ST_WARN_BIT] = overtemp_i;
    assign status[`CPR_ST_OLON_BIT] = open_load_trip_i & on_state_open_load_detect_enable_i;
    assign status[15:2] = other_status_i | (pwm_err ? 14'h0100 : 14'h0000);

    always @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            pwm_ctrl_reg <= `CPR_RST_PWM_CTRL;
            ilim_cfg_reg <= `CPR_RST_ILIM_CFG;
            reg_rdata_o <= 16'h0000;
        end else begin
            if (reg_wr_i && reg_addr_i == `CPR_OFS_PWM_CTRL)
                pwm_ctrl_reg <= reg_wdata_i & `CPR_PWM_WMASK;
            if (reg_wr_i && reg_addr_i == `CPR_OFS_ILIM_CFG)
                ilim_cfg_reg <= reg_wdata_i;
            if (reg_rd_i) begin
                case (reg_addr_i)
                    `CPR_OFS_FAULT_STAT: reg_rdata_o <= status;
                    `CPR_OFS_PWM_CTRL: reg_rdata_o <= pwm_ctrl_reg;
                    `CPR_OFS_ILIM_CFG: reg_rdata_o <= ilim_cfg_reg;
                    default: reg_rdata_o <= 16'h0000;
                endcase
            end
        end
    end

    // Inrush window starts at each switch-on with a charge mode selected and a nonzero duration code
    always @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            sw_d_reg <= 1'b0;
            inrush_cnt_reg <= 23'h0;
        end else begin
            sw_d_reg <= commanded_switch_state_i;
            if (!commanded_switch_state_i)
                inrush_cnt_reg <= 23'h0;
            else if (!sw_d_reg && !mode_ok)
                inrush_cnt_reg <= cpr_inrush_cyc(ilim_cfg_reg[`CPR_DUR_MSB:`CPR_DUR_LSB]);
            else if (inrush_now)
                inrush_cnt_reg <= inrush_cnt_reg - 23'h1;
        end
    end

    always @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            gate_drive_o <= 1'b0;
            inrush_active_o <= 1'b0;
            wire_heating_protection_hold_o <= 1'b0;
            capacitive_charge_mode_o <= 2'h0;
            inrush_pulse_peak_threshold_o <= 2'h0;
            inrush_level_setting_o <= 4'h0;
            pulse_error_o <= 1'b0;
        end else begin
            // Pulsing only when allowed, else plain switch state
            gate_drive_o <= pulse_run ? pulse : commanded_switch_state_i;
            inrush_active_o <= inrush_now;
            wire_heating_protection_hold_o <= inrush_now;
            capacitive_charge_mode_o <= chg_mode;
            inrush_pulse_peak_threshold_o <= ilim_cfg_reg[`CPR_OCP_MSB:`CPR_OCP_LSB];
            inrush_level_setting_o <= ilim_cfg_reg[7:4];
            pulse_error_o <= pwm_err;
        end
    end
endmodule

`default_nettype wire

// ---- hw/cpr_consts.vh ----
`ifndef CPR_CONSTS_VH
`define CPR_CONSTS_VH

// Register indices (printed offsets)
`define CPR_ADDR_W 8
`define CPR_OFS_FAULT_STAT 8'h15
`define CPR_OFS_PWM_CTRL 8'h16
`define CPR_OFS_ILIM_CFG 8'h17

// Reset values
`define CPR_RST_PWM_CTRL 16'h0000
`define CPR_RST_ILIM_CFG 16'h0088

// Pulse control fields
`define CPR_PWM_EN_BIT 0
`define CPR_DUTY_LSB 1
`define CPR_DUTY_MSB 8
`define CPR_FREQ_LSB 9
`define CPR_FREQ_MSB 11
`define CPR_PWM_WMASK 16'h0FFF

// Current limit fields
`define CPR_DUR_LSB 8
`define CPR_DUR_MSB 10
`define CPR_CHG_LSB 12
`define CPR_CHG_MSB 13
`define CPR_OCP_LSB 14
`define CPR_OCP_MSB 15
`define CPR_CHG_NONE 2'h0
`define CPR_CHG_PULSE 2'h3

// Fault status fields
`define CPR_ST_WARN_BIT 0
`define CPR_ST_OLON_BIT 1
`define CPR_ST_FLT_BIT 10
`define CPR_ST_SW_BIT 9

// Timing
`define CPR_CLK_HZ 50000000
`define CPR_MIN_ON_US 200
`define CPR_MIN_ON_CYC ((`CPR_MIN_ON_US * 50) + 0)
`define CPR_MS_CYC 50000

`endif

// ---- hw/cpr_pulse_gen.v ----
`include "cpr_consts.vh"
`default_nettype none

module cpr_pulse_gen (
    // Clock and reset
    input wire clock_i,
    input wire rst_n_i,
    // Control
    input wire run_i,
    input wire [2:0] freq_code_i,
    input wire [7:0] duty_i,
    // Outputs
    output reg pulse_o,
    output wire short_on_o
);
    reg [25:0] step_reg;
    reg [7:0] phase_reg;

    // Clocks per 1/256 of a period for each frequency code
    function [25:0] cpr_step_cyc;
        input [2:0] code;
        begin
            case (code)
                3'h0: cpr_step_cyc = 26'd244141;
                3'h1: cpr_step_cyc = 26'd57445;
                3'h2: cpr_step_cyc = 26'd14154;
                3'h3: cpr_step_cyc = 26'd1760;
                3'h4: cpr_step_cyc = 26'd884;
                3'h5: cpr_step_cyc = 26'd441;
                3'h6: cpr_step_cyc = 26'd221;
                default: cpr_step_cyc = 26'd110;
            endcase
        end
    endfunction

    wire [25:0] step_len = cpr_step_cyc(freq_code_i);
    wire [33:0] on_cyc = step_len * duty_i;

    // On time must exceed the minimum
    assign short_on_o = (on_cyc <= 34'd10000);

    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            step_reg <= 26'h0;
            phase_reg <= 8'h0;
            pulse_o <= 1'b0;
        end else if (!run_i) begin
            step_reg <= 26'h0;
            phase_reg <= 8'h0;
            pulse_o <= 1'b0;
        end else begin
            if (step_reg >= step_len - 26'd1) begin
                step_reg <= 26'h0;
                phase_reg <= phase_reg + 8'h1;
            end else begin
                step_reg <= step_reg + 26'h1;
            end
            pulse_o <= (phase_reg < duty_i);
        end
    end
endmodule

`default_nettype wire

// ---- bench/cpr_ch2_assertions.sv ----
`default_nettype none
module cpr_ch2_chk (
    // Watched ports
    input wire logic clock_i,
    input wire logic arst_n_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [15:0] reg_rdata_o,
    input wire logic commanded_switch_state_i,
    input wire logic on_state_open_load_detect_enable_i,
    input wire logic open_load_trip_i,
    input wire logic overtemp_i,
    input wire logic gate_drive_o,
    input wire logic inrush_active_o,
    input wire logic wire_heating_protection_hold_o,
    input wire logic [1:0] capacitive_charge_mode_o,
    input wire logic [1:0] inrush_pulse_peak_threshold_o,
    input wire logic pulse_error_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!arst_n_i);
    sequence s_rd(a);
        reg_rd_i && reg_addr_i == a;
    endsequence
    // Quiet bus after the write so the copy has settled
    sequence s_cfg_wr;
        reg_wr_i && reg_addr_i == 8'h17 ##1 !reg_wr_i [*2];
    endsequence
    a_warn_live: assert property (
        s_rd(8'h15) |=> reg_rdata_o[0] == $past(overtemp_i)) else $error("warning bit wrong");
    a_olon_gated: assert property (
        s_rd(8'h15) |=> reg_rdata_o[1] == $past(open_load_trip_i
        && on_state_open_load_detect_enable_i)) else $error("open load bit wrong");
    a_unmapped_zero: assert property (reg_rd_i && (reg_addr_i < 8'h15 || reg_addr_i > 8'h17)
        |=> reg_rdata_o == 16'h0000) else $error("unmapped read not zero");
    a_pwm_rsvd: assert property (
        s_rd(8'h16) |=> reg_rdata_o[15:12] == 4'h0) else $error("reserved bits set");
    a_rdata_hold: assert property (!reg_rd_i |=> $stable(reg_rdata_o)) else $error("rdata moved");
    a_mode_copy: assert property (
        s_cfg_wr |-> capacitive_charge_mode_o == $past(reg_wdata_i[13:12], 2))
        else $error("charge mode copy wrong");
    a_peak_copy: assert property (
        s_cfg_wr |-> inrush_pulse_peak_threshold_o == $past(reg_wdata_i[15:14], 2))
        else $error("peak copy wrong");
    a_off_drive: assert property (
        !commanded_switch_state_i [*4] |-> !gate_drive_o) else $error("drive while off");
    a_off_noerr: assert property (
        !commanded_switch_state_i [*4] |-> !pulse_error_o) else $error("error while off");
    a_hold_tracks: assert property (
        inrush_active_o == wire_heating_protection_hold_o) else $error("hold not with inrush");
endmodule
bind cpr_ch2_regs cpr_ch2_chk chk (.*);
`default_nettype wire

// ---- bench/cpr_host_model.sv ----
`default_nettype none
module cpr_host_model (
    input wire logic clock_i,
    input wire logic [15:0] rdata_i,
    output logic [7:0] addr_o,
    output logic [15:0] wdata_o,
    output logic wr_o,
    output logic rd_o
);
    initial {addr_o, wdata_o, wr_o, rd_o} = 26'h0;
    task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d,
        output logic [15:0] q);
        @(negedge clock_i);
        addr_o = a;
        wdata_o = d;
        wr_o = w;
        rd_o = !w;
        @(negedge clock_i);
        wr_o = 1'b0;
        rd_o = 1'b0;
        // Released data must not look valid
        wdata_o = ~d;
        @(negedge clock_i);
        q = rdata_i;
    endtask
endmodule
`default_nettype wire

// ---- bench/testbench.sv ----
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic [7:0] reg_addr_i;
    logic [15:0] reg_wdata_i, reg_rdata_o, q, d;
    logic reg_wr_i, reg_rd_i, gate_drive_o, inrush_active_o, wire_heating_protection_hold_o;
    logic commanded_switch_state_i = 1'b0;
    logic on_state_open_load_detect_enable_i = 1'b0;
    logic open_load_trip_i = 1'b0;
    logic overtemp_i = 1'b0;
    logic [15:2] other_status_i = 14'h0;
    logic [1:0] capacitive_charge_mode_o, inrush_pulse_peak_threshold_o;
    logic [3:0] inrush_level_setting_o;
    logic pulse_error_o;
    integer error_cnt = 0, compares = 0, seed = 32'h5cce, n, i;
    always #10 clock_i = ~clock_i;
    cpr_ch2_regs uut (.*);
    cpr_host_model host (.clock_i(clock_i), .rdata_i(reg_rdata_o), .addr_o(reg_addr_i),
        .wdata_o(reg_wdata_i), .wr_o(reg_wr_i), .rd_o(reg_rd_i));
    task check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task print_verdict;
        if (error_cnt == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task rd(input logic [7:0] a);
        host.acc(1'b0, a, 16'h0000, q);
    endtask
    task wr(input logic [7:0] a, input logic [15:0] v);
        host.acc(1'b1, a, v, q);
    endtask
    task run(input integer c, output integer hi);
        hi = 0;
        repeat (c) begin
            @(negedge clock_i);
            hi += (gate_drive_o === 1'b1);
        end
    endtask
    task sw(input logic v);
        commanded_switch_state_i = v;
        repeat (6) @(negedge clock_i);
    endtask
    initial begin
        repeat (2) @(negedge clock_i);
        arst_n_i = 1'b1;
        repeat (3) @(negedge clock_i);
        rd(8'h16);
        check(q, 16'h0000);
        rd(8'h17);
        check(q, 16'h0088);
        rd(8'h40);
        check(q, 16'h0000);
        for (i = 0; i < 4; i++) begin
            d = $random(seed);
            wr(8'h16, d);
            rd(8'h16);
            check(q, d & 16'h0FFF);
            wr(8'h17, d);
            rd(8'h17);
            check(q, d);
        end
        wr(8'h15, 16'hFFFF);
        for (i = 0; i < 8; i++) begin
            {overtemp_i, open_load_trip_i, on_state_open_load_detect_enable_i} = i;
            other_status_i = $random(seed);
            repeat (3) @(negedge clock_i);
            rd(8'h15);
            check({14'h0, q[1:0]}, {14'h0, open_load_trip_i & (i % 2 == 1), overtemp_i});
            check({2'h0, q[15:2]}, {2'h0, other_status_i});
        end
        // Quiet other faults so the pulse error bit stands alone
        other_status_i = 14'h0;
        wr(8'h17, 16'h0088);
        wr(8'h16, 16'h0E01);
        sw(1'b1);
        check({15'h0, pulse_error_o}, 16'h0001);
        rd(8'h15);
        check(q & 16'h0400, 16'h0400);
        // Duty 128 at the fastest rate: about half of one period
        wr(8'h16, 16'h0F01);
        repeat (5) @(negedge clock_i);
        check({15'h0, pulse_error_o}, 16'h0000);
        run(28248, n);
        check(n / 1000, 16'd14);
        wr(8'h16, 16'h0F00);
        repeat (3) @(negedge clock_i);
        run(1000, n);
        check(n, 16'd1000);
        sw(1'b0);
        wr(8'h17, 16'h1088);
        wr(8'h16, 16'h0F01);
        sw(1'b1);
        check({15'h0, pulse_error_o}, 16'h0001);
        run(1000, n);
        check(n, 16'd1000);
        sw(1'b0);
        wr(8'h17, 16'h3188);
        sw(1'b1);
        check({15'h0, inrush_active_o}, 16'h0001);
        check({15'h0, wire_heating_protection_hold_o}, 16'h0001);
        check({12'h0, inrush_level_setting_o}, 16'h0008);
        sw(1'b0);
        print_verdict;
    end
    initial begin
        #1500000;
        error_cnt++;
        print_verdict;
    end
endmodule
`default_nettype wire
